// File: core/pocl_top.sv
/*
 * pocl_top: power-on strap configuration latch.
 * Takes the device configuration from the memory data byte as reset is
 * released, keeps host bus and memory strobes quiet until then, and
 * offers the result on outputs and over a small register port.
 * assumes: straps or a boot memory hold the data byte steady during and
 * shortly after reset; core requests arrive on clk_i.
 */
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module pocl_top (
  input  wire logic                        clk_i,
  input  wire logic                        resetn_i,
  input  wire logic                        clk_en_i,
  // memory data byte pins and memory strobes
  input  wire logic [pocl_pkg::STRAP_W-1:0] memory_data_byte_i,
  output logic      [pocl_pkg::STRAP_W-1:0] memory_data_byte_o,
  output logic                             memory_data_byte_oe_o,
  output logic                             mem_ras_n_o,
  output logic                             mem_oe_n_o,
  // requests from the memory controller
  input  wire logic                        mem_ras_req_i,
  input  wire logic                        mem_oe_req_i,
  input  wire logic                        mem_wr_req_i,
  input  wire logic [pocl_pkg::STRAP_W-1:0] mem_wdata_i,
  // host bus drive gate
  input  wire logic                        host_drive_req_i,
  output logic                             host_bus_oe_o,
  // decoded configuration
  output logic                             cfg_valid_o,
  output logic                             bus_is_vl_o,
  output logic      [1:0]                  board_type_o,
  output logic      [1:0]                  fb_type_o,
  output logic                             fb_type_bad_o,
  // register port
  input  wire logic [pocl_pkg::ADDR_W-1:0]  reg_addr_i,
  input  wire logic [pocl_pkg::DATA_W-1:0]  reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [pocl_pkg::DATA_W-1:0]  reg_rdata_o
);

  // -------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------
  logic [pocl_pkg::STRAP_W-1:0] strap_sync;
  logic [pocl_pkg::CFG_W-1:0]   cfg_q;
  logic                         cfg_ok;

  pocl_pkg::pocl_state_t state_ff;
  pocl_pkg::pocl_state_t nxt_state;

  logic [1:0] settle_ff;
  logic       load_pulse;
  logic       running;

  logic [1:0] ctl_ff;
  logic       mem_en;
  logic       host_en;

  logic [pocl_pkg::STRAP_W-1:0] mdb_out_ff;
  logic                         mdb_oe_ff;
  logic                         ras_n_ff;
  logic                         oe_n_ff;
  logic                         host_oe_ff;

  logic                         cfg_valid_ff;
  logic                         bus_vl_ff;
  logic [1:0]                   board_ff;
  logic [1:0]                   fb_ff;
  logic                         fb_bad_ff;

  logic [pocl_pkg::DATA_W-1:0]  rdata_ff;
  logic [pocl_pkg::DATA_W-1:0]  nxt_rdata;

  // -------------------------------------------------------------------
  // strap synchroniser
  // -------------------------------------------------------------------
  // the pins float to resistor levels, so they are asynchronous to clk_i
  pocl_sync #(
    .WIDTH (pocl_pkg::STRAP_W)
  ) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .clk_en_i (clk_en_i),
    .async_i  (memory_data_byte_i),
    .sync_o   (strap_sync)
  );

  // -------------------------------------------------------------------
  // release sequencer
  // -------------------------------------------------------------------
  // the synchroniser is cleared by reset, so the strap is taken only
  // after its chain has refilled with pin levels
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      settle_ff <= 2'h0;
    end else if (clk_en_i && state_ff == pocl_pkg::POCL_SETTLE) begin
      settle_ff <= settle_ff + 2'h1;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pocl_pkg::POCL_SETTLE: begin
        if (settle_ff == pocl_pkg::SETTLE_CYCLES - 2'h1) begin
          nxt_state = pocl_pkg::POCL_CAPTURE;
        end
      end
      pocl_pkg::POCL_CAPTURE: begin
        nxt_state = pocl_pkg::POCL_RUN;
      end
      pocl_pkg::POCL_RUN: begin
        nxt_state = pocl_pkg::POCL_RUN;
      end
      default: begin
        nxt_state = pocl_pkg::POCL_SETTLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= pocl_pkg::POCL_SETTLE;
    end else if (clk_en_i) begin
      state_ff <= nxt_state;
    end
  end

  assign load_pulse = (state_ff == pocl_pkg::POCL_CAPTURE);
  assign running    = (state_ff == pocl_pkg::POCL_RUN);

  // -------------------------------------------------------------------
  // configuration hold
  // -------------------------------------------------------------------
  // upper strap bits never reach the holding register
  pocl_capture u_capture (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .clk_en_i (clk_en_i),
    .load_i   (load_pulse),
    .data_i   (strap_sync[pocl_pkg::CFG_W-1:0]),
    .cfg_o    (cfg_q),
    .valid_o  (cfg_ok)
  );

  // -------------------------------------------------------------------
  // decoded outputs
  // -------------------------------------------------------------------
  // every field trails the held value by one cycle, so all of them
  // change together with the valid flag
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_valid_ff <= 1'b0;
    end else if (clk_en_i) begin
      cfg_valid_ff <= cfg_ok;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_vl_ff <= 1'b0;
    end else if (clk_en_i) begin
      bus_vl_ff <= cfg_q[pocl_pkg::BUS_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      board_ff <= pocl_pkg::BOARD_MOBO;
    end else if (clk_en_i) begin
      board_ff <= cfg_q[pocl_pkg::BOARD_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fb_ff <= pocl_pkg::FB_VRAM;
    end else if (clk_en_i) begin
      fb_ff <= cfg_q[pocl_pkg::FB_LSB +: 2];
    end
  end

  // an illegal code is only flagged; the raw code still goes out
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fb_bad_ff <= 1'b0;
    end else if (clk_en_i) begin
      fb_bad_ff <= cfg_ok && pocl_pkg::fb_illegal(cfg_q[pocl_pkg::FB_LSB +: 2]);
    end
  end

  // -------------------------------------------------------------------
  // control register
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_ff <= pocl_pkg::CTL_RESET;
    end else if (clk_en_i && reg_wr_i && reg_addr_i == pocl_pkg::OFS_CONTROL) begin
      ctl_ff <= reg_wdata_i[1:0];
    end
  end

  assign mem_en  = ctl_ff[pocl_pkg::CTL_MEM_EN_BIT];
  assign host_en = ctl_ff[pocl_pkg::CTL_HOST_EN_BIT];

  // -------------------------------------------------------------------
  // memory interface gate
  // -------------------------------------------------------------------
  // the asynchronous reset forces the quiet levels at once, without
  // waiting for a clock, and they stay until the strap is held
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ras_n_ff <= 1'b1;
    end else if (clk_en_i) begin
      ras_n_ff <= !(running && mem_en && mem_ras_req_i);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      oe_n_ff <= 1'b1;
    end else if (clk_en_i) begin
      oe_n_ff <= !(running && mem_en && mem_oe_req_i);
    end
  end

  // a read strobe and a write drive are never given together
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mdb_oe_ff  <= 1'b0;
      mdb_out_ff <= 8'h00;
    end else if (clk_en_i) begin
      mdb_oe_ff  <= running && mem_en && mem_wr_req_i && !mem_oe_req_i;
      mdb_out_ff <= mem_wdata_i;
    end
  end

  // -------------------------------------------------------------------
  // host bus gate
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_oe_ff <= 1'b0;
    end else if (clk_en_i) begin
      host_oe_ff <= running && host_en && host_drive_req_i;
    end
  end

  // -------------------------------------------------------------------
  // register read
  // -------------------------------------------------------------------
  // unmapped offsets and reserved bits read as zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (reg_addr_i)
      pocl_pkg::OFS_CONFIG: begin
        nxt_rdata[pocl_pkg::CFG_W-1:0] = cfg_q;
      end
      pocl_pkg::OFS_STATUS: begin
        nxt_rdata[pocl_pkg::ST_CAPTURED_BIT] = cfg_ok;
        nxt_rdata[pocl_pkg::ST_FB_BAD_BIT]   = fb_bad_ff;
        nxt_rdata[pocl_pkg::ST_MEM_ON_BIT]   = running && mem_en;
        nxt_rdata[pocl_pkg::ST_HOST_ON_BIT]  = running && host_en;
      end
      pocl_pkg::OFS_CONTROL: begin
        nxt_rdata[1:0] = ctl_ff;
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (clk_en_i) begin
      rdata_ff <= reg_rd_i ? nxt_rdata : 32'h0000_0000;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign memory_data_byte_o    = mdb_out_ff;
  assign memory_data_byte_oe_o = mdb_oe_ff;
  assign mem_ras_n_o           = ras_n_ff;
  assign mem_oe_n_o            = oe_n_ff;
  assign host_bus_oe_o         = host_oe_ff;
  assign cfg_valid_o           = cfg_valid_ff;
  assign bus_is_vl_o           = bus_vl_ff;
  assign board_type_o          = board_ff;
  assign fb_type_o             = fb_ff;
  assign fb_type_bad_o         = fb_bad_ff;
  assign reg_rdata_o           = rdata_ff;

endmodule : pocl_top

// File: common/pocl_pkg.sv
/*
 * pocl_pkg: constants, states and decode helpers for the power-on strap
 * configuration latch.
 * assumes: one clock domain, registers reached over a plain strobe port.
 */
package pocl_pkg;

  // -------------------------------------------------------------------
  // strap layout
  // -------------------------------------------------------------------
  localparam int unsigned STRAP_W     = 8;
  localparam int unsigned CFG_W       = 5;
  localparam int unsigned BUS_BIT     = 4;
  localparam int unsigned BOARD_LSB   = 2;
  localparam int unsigned FB_LSB      = 0;
  localparam int unsigned SYNC_STAGES = 2;

  localparam logic [1:0] FB_VRAM     = 2'h0;
  localparam logic [1:0] FB_DRAM     = 2'h3;
  localparam logic [1:0] BOARD_MOBO  = 2'h0;
  localparam logic [1:0] BOARD_ADP1  = 2'h1;

  // -------------------------------------------------------------------
  // register port
  // -------------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  localparam logic [3:0] OFS_CONFIG  = 4'h0;
  localparam logic [3:0] OFS_STATUS  = 4'h4;
  localparam logic [3:0] OFS_CONTROL = 4'h8;

  localparam int unsigned ST_CAPTURED_BIT = 0;
  localparam int unsigned ST_FB_BAD_BIT   = 1;
  localparam int unsigned ST_MEM_ON_BIT   = 2;
  localparam int unsigned ST_HOST_ON_BIT  = 3;

  localparam int unsigned CTL_MEM_EN_BIT  = 0;
  localparam int unsigned CTL_HOST_EN_BIT = 1;
  localparam logic [1:0]  CTL_RESET       = 2'h3;

  // cycles after reset release before the synchronised strap is valid
  localparam logic [1:0] SETTLE_CYCLES = 2'(SYNC_STAGES);

  localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;

  // -------------------------------------------------------------------
  // sequencer states, gray coded along the path
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    POCL_SETTLE  = 2'h0,
    POCL_CAPTURE = 2'h1,
    POCL_RUN     = 2'h3
  } pocl_state_t;

  // codes 01 and 10 of the frame buffer field must never be strapped
  function automatic logic fb_illegal(input logic [1:0] code);
    fb_illegal = (code != FB_VRAM) && (code != FB_DRAM);
  endfunction : fb_illegal

endpackage : pocl_pkg

// File: core/pocl_sync.sv
/*
 * pocl_sync: multi-bit two-stage synchroniser for static pin levels.
 * assumes: the bits are quasi-static straps, so no bus coherence is needed.
 */
`timescale 1ns/1ns
module pocl_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             clk_en_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // -------------------------------------------------------------------
  // one two-flop chain per bit
  // -------------------------------------------------------------------
  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        meta_ff[g] <= 1'b0;
        sync_ff[g] <= 1'b0;
      end else if (clk_en_i) begin
        meta_ff[g] <= async_i[g];
        sync_ff[g] <= meta_ff[g];
      end
    end
  end

  assign sync_o = sync_ff;

endmodule : pocl_sync

// File: core/pocl_capture.sv
/*
 * pocl_capture: holding register for the synchronised strap value.
 * assumes: load_i is a one-cycle pulse given once per reset release.
 */
`timescale 1ns/1ns
module pocl_capture (
  input  wire logic                      clk_i,
  input  wire logic                      resetn_i,
  input  wire logic                      clk_en_i,
  input  wire logic                      load_i,
  input  wire logic [pocl_pkg::CFG_W-1:0] data_i,
  output logic      [pocl_pkg::CFG_W-1:0] cfg_o,
  output logic                           valid_o
);

  logic [pocl_pkg::CFG_W-1:0] cfg_ff;
  logic                       valid_ff;

  // -------------------------------------------------------------------
  // hold
  // -------------------------------------------------------------------
  // loads once, then ignores the bus until the next reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_ff <= pocl_pkg::CFG_RESET;
    end else if (clk_en_i && load_i && !valid_ff) begin
      cfg_ff <= data_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      valid_ff <= 1'b0;
    end else if (clk_en_i && load_i) begin
      valid_ff <= 1'b1;
    end
  end

  assign cfg_o   = cfg_ff;
  assign valid_o = valid_ff;

endmodule : pocl_capture

// File: tb/pocl_top_assertions.sv
/* pocl_top_assertions: port timing checks for the strap latch.
   assumes: bound into pocl_top; clk_en_i high around each reset release. */
`timescale 1ns/1ns
module pocl_top_assertions (
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic [7:0] memory_data_byte_i,
  input wire logic       memory_data_byte_oe_o,
  input wire logic       mem_ras_n_o,
  input wire logic       mem_oe_n_o,
  input wire logic       host_bus_oe_o,
  input wire logic       cfg_valid_o,
  input wire logic       bus_is_vl_o,
  input wire logic [1:0] board_type_o,
  input wire logic [1:0] fb_type_o,
  input wire logic       fb_type_bad_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // pin history: ties the capture to the levels seen just after release
  logic [7:0] pin_d1_ff;
  logic [7:0] pin_d2_ff;
  logic [7:0] pin_d3_ff;
  always_ff @(posedge clk_i) begin
    pin_d1_ff <= memory_data_byte_i;
    pin_d2_ff <= pin_d1_ff;
    pin_d3_ff <= pin_d2_ff;
  end
  // --------------------------------------------------------------
  // pins quiet for four cycles after reset release, until the capture is done
  // --------------------------------------------------------------
  a_host_quiet: assert property ($rose(resetn_i) |-> !host_bus_oe_o [*4])
    else $error("host bus driven too early after reset");
  a_mem_quiet: assert property ($rose(resetn_i) |-> (mem_ras_n_o && mem_oe_n_o) [*4])
    else $error("memory strobes active too early after reset");
  a_bus_float: assert property ($rose(resetn_i) |-> !memory_data_byte_oe_o [*4])
    else $error("data byte driven too early after reset");
  // --------------------------------------------------------------
  // capture and decode
  // --------------------------------------------------------------
  a_valid_time: assert property ($rose(resetn_i) |-> !cfg_valid_o [*4] ##1 cfg_valid_o)
    else $error("configuration not valid at the expected edge");
  a_bus_decode: assert property ($rose(cfg_valid_o) |-> bus_is_vl_o == pin_d3_ff[4])
    else $error("bus type differs from strap");
  a_board_decode: assert property ($rose(cfg_valid_o) |-> board_type_o == pin_d3_ff[3:2])
    else $error("board type differs from strap");
  a_fb_decode: assert property ($rose(cfg_valid_o) |-> fb_type_o == pin_d3_ff[1:0])
    else $error("frame buffer type differs from strap");
  a_fb_flag: assert property (fb_type_bad_o == (cfg_valid_o && fb_type_o inside {2'h1, 2'h2}))
    else $error("illegal frame buffer flag wrong");
  a_cfg_hold: assert property (cfg_valid_o |=> cfg_valid_o
    && $stable({bus_is_vl_o, board_type_o, fb_type_o}))
    else $error("latched configuration changed");
  cover property ($rose(cfg_valid_o) && bus_is_vl_o);
  cover property ($rose(fb_type_bad_o));
  cover property ($rose(host_bus_oe_o));
endmodule : pocl_top_assertions

// File: tb/pocl_strap_model.sv
/* pocl_strap_model: resistor straps on the memory data byte.
   assumes: the latch drives the pins only while its output enable is high. */
`timescale 1ns/1ns
module pocl_strap_model (
  input  wire logic [7:0] strap_i,
  input  wire logic       drive_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] pins_o
);
  // one resistor per bit, so a released bit never floats; a driver wins
  assign pins_o = drive_i ? data_i : strap_i;
endmodule : pocl_strap_model

// File: tb/pocl_top_test.sv
/* pocl_top_test: self-checking bench for the strap latch, checker bind.
   assumes: straps come from pocl_strap_model; clock enable dropped only at the end. */
`timescale 1ns/1ns
module pocl_top_test;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        clk_en = 1'b1;
  logic [7:0]  strap = 8'h00;
  wire  [7:0]  pins;
  logic [7:0]  mdb_o;
  logic [1:0]  board;
  logic [1:0]  fb;
  logic        mdb_oe, ras_n, oe_n, host_oe, cfg_valid, bus_vl, fb_bad;
  logic        ras_req = 1'b0, oe_req = 1'b0, wr_req = 1'b0, host_req = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [3:0]  addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0, reg_rd = 1'b0;
  logic [31:0] rdata;
  logic [15:0] lfsr_q = 16'h5c62;
  int          fail_count = 0;
  int          check_count = 0;

  always #5 clk_i = ~clk_i;

  pocl_top u_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en),
    .memory_data_byte_i(pins), .memory_data_byte_o(mdb_o),
    .memory_data_byte_oe_o(mdb_oe), .mem_ras_n_o(ras_n), .mem_oe_n_o(oe_n),
    .mem_ras_req_i(ras_req), .mem_oe_req_i(oe_req), .mem_wr_req_i(wr_req),
    .mem_wdata_i(wdata), .host_drive_req_i(host_req), .host_bus_oe_o(host_oe),
    .cfg_valid_o(cfg_valid), .bus_is_vl_o(bus_vl), .board_type_o(board),
    .fb_type_o(fb), .fb_type_bad_o(fb_bad), .reg_addr_i(addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata)
  );
  pocl_strap_model u_straps (
    .strap_i(strap), .drive_i(mdb_oe), .data_i(mdb_o), .pins_o(pins)
  );

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [7:0] rnd8();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q[7:0];
  endfunction : rnd8

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_i);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_i);
    reg_rd <= 1'b0;
    #1 check(rdata, exp);
  endtask : rd_chk

  // requests stay raised through reset: the gates must still hold off
  task automatic do_reset(input logic [7:0] s);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    strap <= s;
    {ras_req, oe_req, host_req} <= 3'h7;
    repeat (15) @(posedge clk_i);
    #1 check(32'({pins, ras_n, oe_n, mdb_oe, host_oe}), 32'({s, 4'hc}));
    @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    #1 check(32'({ras_n, oe_n, mdb_oe, host_oe}), 32'h0000_0001);
    @(posedge clk_i);
    {ras_req, oe_req, host_req} <= 3'h0;
    #1;
  endtask : do_reset

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    logic [7:0] s;
    logic [7:0] w;
    int         exp_cfg;
    int         bad;
    // every bus, board and frame buffer code, upper bits random
    for (int k = 0; k < 4; k++) begin
      s = rnd8();
      s[4:0] = {k[0], k[1:0], k[1:0]};
      exp_cfg = s & 8'h1f;
      bad = (exp_cfg % 4 == 1) || (exp_cfg % 4 == 2);
      do_reset(s);
      check(32'({bus_vl, board, fb}), exp_cfg);
      check(32'(fb_bad), bad);
      rd_chk(pocl_pkg::OFS_CONFIG, exp_cfg);
      rd_chk(pocl_pkg::OFS_STATUS, 32'h0000_000d | (bad << 1));
      @(posedge clk_i);
      strap <= rnd8();
      repeat (4) @(posedge clk_i);
      #1 check(32'({cfg_valid, bus_vl, board, fb}), exp_cfg | 32);
      rd_chk(pocl_pkg::OFS_CONFIG, exp_cfg);
    end
    // write data reaches the pins once running
    w = rnd8();
    @(posedge clk_i);
    wdata <= w;
    wr_req <= 1'b1;
    @(posedge clk_i);
    #1 check(32'({mdb_oe, pins}), 32'({1'b1, w}));
    @(posedge clk_i);
    wr_req <= 1'b0;
    // gates disabled by software, read-only and unmapped places
    reg_write(pocl_pkg::OFS_CONTROL, 32'h0000_0000);
    @(posedge clk_i);
    {ras_req, host_req} <= 2'h3;
    repeat (2) @(posedge clk_i);
    #1 check(32'({ras_n, host_oe}), 32'h0000_0002);
    rd_chk(pocl_pkg::OFS_CONTROL, 32'h0000_0000);
    rd_chk(pocl_pkg::OFS_STATUS, 32'h0000_0001);
    reg_write(pocl_pkg::OFS_CONFIG, 32'hffff_ffff);
    rd_chk(pocl_pkg::OFS_CONFIG, exp_cfg);
    rd_chk(4'hc, 32'h0000_0000);
    reg_write(pocl_pkg::OFS_CONTROL, 32'h0000_0003);
    rd_chk(pocl_pkg::OFS_CONTROL, 32'h0000_0003);
    // clock enable low freezes the gates although the request falls
    @(posedge clk_i);
    clk_en <= 1'b0;
    ras_req <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1 check(32'({ras_n, host_oe}), 32'h0000_0001);
    @(posedge clk_i);
    clk_en <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 check(32'({ras_n, host_oe}), 32'h0000_0003);
    results();
  end

  initial begin
    #200000;
    fail_count++;
    results();
  end
endmodule : pocl_top_test

bind pocl_top pocl_top_assertions u_chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .memory_data_byte_i(memory_data_byte_i),
  .memory_data_byte_oe_o(memory_data_byte_oe_o), .mem_ras_n_o(mem_ras_n_o),
  .mem_oe_n_o(mem_oe_n_o), .host_bus_oe_o(host_bus_oe_o), .cfg_valid_o(cfg_valid_o),
  .bus_is_vl_o(bus_is_vl_o), .board_type_o(board_type_o), .fb_type_o(fb_type_o),
  .fb_type_bad_o(fb_type_bad_o)
);
